// >>> dv/card_model.sv
// card stand-in: hands the receiver frame ends with a bit count
// assumes the bench asks for one frame at a time
`timescale 1ns/1ps
module card_model (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       send_i,
    input  wire logic [7:0] bits_i,
    output logic            frame_end_o,
    output logic [7:0]      frame_bits_o
);
    // count only holds with the end pulse, it churns otherwise
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            frame_end_o <= 1'b0;
            frame_bits_o <= 8'ha5;
        end else begin
            frame_end_o <= send_i;
            frame_bits_o <= send_i ? bits_i : ~frame_bits_o;
        end
    end
endmodule : card_model

// >>> dv/nfc_mode_properties.sv
// properties of the mode configuration block, bound to its ports
// assumes 8-bit registers written through wb_sel_i[0]
`timescale 1ns/1ps
module nfc_mode_properties
    import nfc_mode_pkg::*;
(
    input logic        sys_clk_i,
    input logic        rst_n_i,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [9:0]  wb_adr_i,
    input logic [3:0]  wb_sel_i,
    input logic [31:0] wb_dat_i,
    input logic        wb_ack_o,
    input logic        wb_err_o,
    input logic        tx_busy_i,
    input logic        mod_bit_i,
    input logic        mod_valid_i,
    input logic        tx_bit_o,
    input logic        tx_valid_o,
    input logic        tx_crc_enable_o,
    input logic [2:0]  tx_bit_rate_o,
    input logic [1:0]  tx_frame_format_o,
    input logic        rx_frame_end_i,
    input logic        rx_enable_o,
    input logic        rx_frame_keep_o,
    input logic        rx_frame_drop_o,
    input logic        cmd_done_o,
    input logic [7:0]  rx_frame_bits_i,
    input logic [15:0] crc_seed_o
);
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    // request decode and expected values
    wire        take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire [7:0]  idx = wb_adr_i[9:2];
    wire        wr = take & wb_we_i & wb_sel_i[0];
    wire        known = idx == IDX_MODE || idx == IDX_TX_MODE ||
        idx == IDX_RX_MODE || idx == IDX_COMMAND || idx == IDX_RX_STATUS;
    wire        fin = rx_enable_o & rx_frame_end_i;
    wire        frag = rx_r[NOERR_BIT] && rx_frame_bits_i < MIN_FRAG_BITS;
    wire        stop = wr && idx == IDX_COMMAND &&
        wb_dat_i[3:0] != CMD_RECEIVE && wb_dat_i[3:0] != CMD_TRANSCEIVE;
    wire        inv = mod_bit_i ^ tx_r[INV_BIT];
    wire [5:0]  txf = {tx_r[7:4], tx_r[1:0]};
    wire [15:0] seed_rf = tx_r[1:0] == FRAME_TYPE_B ? SEED_3 : SEED_1;
    // shadow copies of the two mode registers
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tx_r <= 8'h00;
            rx_r <= 8'h00;
        end else if (wr && idx == IDX_TX_MODE) begin
            tx_r <= wb_dat_i[7:0];
        end else if (wr && idx == IDX_RX_MODE) begin
            rx_r <= wb_dat_i[7:0];
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_bus_answer: assert property (take && known |=> wb_ack_o && !wb_err_o)
        else $error("mapped request not acknowledged");
    chk_bus_refuse: assert property (take && !known |=> wb_err_o && !wb_ack_o)
        else $error("unmapped request not refused");
    chk_tx_fields: assert property (
        {tx_crc_enable_o, tx_bit_rate_o, tx_frame_format_o} == $past(txf))
        else $error("transmit field copy wrong");
    chk_tx_invert: assert property (
        mod_valid_i |=> tx_valid_o && tx_bit_o == $past(inv))
        else $error("output bit not shaped");
    chk_rf_seed: assert property (
        tx_busy_i && $past(tx_busy_i) && $stable(tx_r)
        |=> crc_seed_o == $past(seed_rf))
        else $error("seed during traffic wrong");
    chk_single_stop: assert property (
        fin && !rx_r[MULTI_BIT] && !frag
        |=> cmd_done_o && rx_frame_keep_o && !rx_enable_o)
        else $error("single frame did not end reception");
    chk_multi_stay: assert property (
        fin && rx_r[MULTI_BIT] |=> !cmd_done_o && rx_enable_o)
        else $error("multi frame reception ended");
    chk_frag_drop: assert property (
        fin && frag |=> rx_frame_drop_o && !rx_frame_keep_o && rx_enable_o)
        else $error("short fragment not dropped");
    chk_cmd_stop: assert property (
        rx_enable_o && stop |-> ##[1:4] !rx_enable_o)
        else $error("command did not stop reception");
    cover property (fin && frag);
    cover property (take && !known);
    cover property (tx_busy_i && tx_r[1:0] == FRAME_TYPE_B);
endmodule : nfc_mode_properties

bind nfc_tx_rx_mode_config nfc_mode_properties nfc_mode_properties_i (.*);

// >>> dv/test_nfc_tx_rx_mode_config.sv
// self-checking bench for the mode configuration block
// assumes the card model and the bound checker are compiled first
`timescale 1ns/1ps
module test_nfc_tx_rx_mode_config;
    import nfc_mode_pkg::*;
    logic        sys_clk_i = 1'b0, rst_n_i = 1'b0;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, bus_err;
    logic [9:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        tx_busy_i, mod_bit_i, mod_valid_i, tx_bit_o, tx_valid_o, b;
    logic        tx_crc_enable_o, rx_crc_enable_o, rx_frame_end_i, send;
    logic [2:0]  tx_bit_rate_o, rx_bit_rate_o;
    logic [1:0]  tx_frame_format_o, rx_frame_format_o;
    logic        rx_enable_o, rx_frame_keep_o, rx_frame_drop_o, cmd_done_o;
    logic [7:0]  rx_frame_bits_i, send_bits, t, r;
    logic [15:0] crc_seed_o;
    logic [15:0] seeds [4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
    int          err_count = 0;
    int          comparisons = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    nfc_tx_rx_mode_config nfc_tx_rx_mode_config_i (.*);
    card_model card_model_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .send_i(send), .bits_i(send_bits), .frame_end_o(rx_frame_end_i),
        .frame_bits_o(rx_frame_bits_i));
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // one classic cycle, held until ack or err is sampled
    task automatic wb(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
        int n = 0;
        @(posedge sys_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h00_0000, d};
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        bus_err = wb_err_o;
        if (n >= 20) begin
            err_count++;
            $display("FAIL %0t bus answer missing", $time);
            end_of_test();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00);
        cmp(rd[15:0], {8'h00, e});
    endtask : rd_chk
    task automatic frame(input logic [7:0] n);
        send <= 1'b1;
        send_bits <= n;
        @(posedge sys_clk_i);
        send <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask : frame
    task automatic rx_start(input logic [3:0] c);
        wb(1'b1, IDX_COMMAND, {4'h0, c});
        repeat (3) @(posedge sys_clk_i);
        cmp(16'(rx_enable_o), 16'h0001);
    endtask : rx_start
    task automatic rx_stop;
        for (int n = 0; n < 6 && rx_enable_o !== 1'b0; n++) @(posedge sys_clk_i);
        cmp(16'(rx_enable_o), 16'h0000);
    endtask : rx_stop
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, tx_busy_i, mod_bit_i, mod_valid_i} = '0;
        {wb_adr_i, wb_dat_i, send, send_bits} = '0;
        wb_sel_i = 4'h1;
        void'($urandom(99));
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        // reset values, reset seed, unmapped index
        rd_chk(IDX_TX_MODE, 8'h00);
        rd_chk(IDX_RX_MODE, 8'h00);
        rd_chk(IDX_MODE, 8'h3d);
        cmp(crc_seed_o, 16'h6363);
        wb(1'b1, 8'h3f, 8'hff);
        cmp(16'(bus_err), 16'h0001);
        // every seed code with the link idle
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, IDX_MODE, 8'h3c | 8'(c));
            repeat (2) @(posedge sys_clk_i);
            cmp(crc_seed_o, seeds[c]);
        end
        // seed follows framing while the transmitter runs
        // standalone code 10 differs from both automatic seeds
        wb(1'b1, IDX_MODE, 8'h3e);
        for (int f = 0; f < 2; f++) begin
            wb(1'b1, IDX_TX_MODE, f ? 8'h03 : 8'h00);
            tx_busy_i <= 1'b1;
            repeat (3) @(posedge sys_clk_i);
            cmp(crc_seed_o, f ? 16'hffff : 16'h6363);
            tx_busy_i <= 1'b0;
        end
        // random legal settings, field copies and inversion
        for (int i = 0; i < 16; i++) begin
            t = 8'($urandom) & 8'hbb;
            r = 8'($urandom) & 8'hbb;
            t[1] = t[0];
            r[1] = r[0];
            wb(1'b1, IDX_TX_MODE, t);
            wb(1'b1, IDX_RX_MODE, r);
            rd_chk(IDX_TX_MODE, t);
            rd_chk(IDX_RX_MODE, r);
            b = 1'($urandom);
            mod_bit_i <= b;
            mod_valid_i <= 1'b1;
            @(posedge sys_clk_i);
            mod_valid_i <= 1'b0;
            @(posedge sys_clk_i);
            cmp(16'({tx_valid_o, tx_bit_o}), 16'({1'b1, b ^ t[3]}));
            cmp(16'({tx_crc_enable_o, tx_bit_rate_o, tx_frame_format_o}),
                16'({t[7:4], t[1:0]}));
            cmp(16'({rx_crc_enable_o, rx_bit_rate_o, rx_frame_format_o}),
                16'({r[7:4], r[1:0]}));
        end
        // single frame ends the receive command
        wb(1'b1, IDX_RX_MODE, 8'h00);
        rx_start(CMD_RECEIVE);
        frame(8'h08);
        cmp(16'({rx_frame_keep_o, cmd_done_o, rx_enable_o}), 16'h0006);
        rd_chk(IDX_COMMAND, 8'h00);
        // fragment dropped, frame kept, stop by command
        wb(1'b1, IDX_RX_MODE, 8'h0c);
        rx_start(CMD_RECEIVE);
        frame(8'h03);
        cmp(16'({rx_frame_drop_o, cmd_done_o, rx_enable_o}), 16'h0005);
        frame(8'h04);
        cmp(16'({rx_frame_keep_o, cmd_done_o, rx_enable_o}), 16'h0005);
        wb(1'b1, IDX_COMMAND, {4'h0, CMD_IDLE});
        rx_stop();
        // transceive ended by clearing the multi-frame bit
        rx_start(CMD_TRANSCEIVE);
        frame(8'h10);
        cmp(16'(rx_enable_o), 16'h0001);
        wb(1'b1, IDX_RX_MODE, 8'h08);
        rx_stop();
        end_of_test();
    end
    // watchdog far beyond the expected run length
    initial begin
        #500000;
        err_count++;
        end_of_test();
    end
endmodule : test_nfc_tx_rx_mode_config

// >>> src/nfc_crc_seed.sv
// crc seed selection between standalone and rf communication
// assumes mode settings are stable while rf traffic runs
`timescale 1ns/1ps
module nfc_crc_seed
    import nfc_mode_pkg::*;
(
    input  wire logic [1:0]  crc_seed_select_i,
    input  wire logic        rf_active_i,
    input  wire logic [1:0]  tx_frame_format_i,
    output logic      [15:0] seed_o
);
    // type b frames start from all ones, type a from 6363h
    wire logic [1:0] auto_code;
    assign auto_code = (tx_frame_format_i == FRAME_TYPE_B) ? 2'b11 : 2'b01;
    // rf traffic overrides the host selector
    assign seed_o = rf_active_i ? seed_of(auto_code)
                                : seed_of(crc_seed_select_i);
endmodule : nfc_crc_seed

// >>> src/nfc_mode_pkg.sv
// package for the transmit/receive mode configuration block
// assumes a classic wishbone slave with 32-bit data, 8-bit registers
package nfc_mode_pkg;
    // register indices, byte address is four times the index
    localparam logic [7:0]  IDX_MODE       = 8'h11;
    localparam logic [7:0]  IDX_TX_MODE    = 8'h12;
    localparam logic [7:0]  IDX_RX_MODE    = 8'h13;
    localparam logic [7:0]  IDX_COMMAND    = 8'h01;
    localparam logic [7:0]  IDX_RX_STATUS  = 8'h20;
    // reset values
    localparam logic [7:0]  MODE_RST       = 8'h3d;
    localparam logic [7:0]  TX_MODE_RST    = 8'h00;
    localparam logic [7:0]  RX_MODE_RST    = 8'h00;
    localparam logic [3:0]  COMMAND_RST    = 4'h0;
    // field positions
    localparam int          CRC_EN_BIT     = 7;
    localparam int          RATE_LSB       = 4;
    localparam int          INV_BIT        = 3;
    localparam int          NOERR_BIT      = 3;
    localparam int          MULTI_BIT      = 2;
    localparam int          FRAME_LSB      = 0;
    // crc seeds
    localparam logic [15:0] SEED_0         = 16'h0000;
    localparam logic [15:0] SEED_1         = 16'h6363;
    localparam logic [15:0] SEED_2         = 16'ha671;
    localparam logic [15:0] SEED_3         = 16'hffff;
    // frame formats
    localparam logic [1:0]  FRAME_TYPE_A   = 2'b00;
    localparam logic [1:0]  FRAME_TYPE_B   = 2'b11;
    // command codes
    localparam logic [3:0]  CMD_IDLE       = 4'h0;
    localparam logic [3:0]  CMD_CRC        = 4'h3;
    localparam logic [3:0]  CMD_TRANSMIT   = 4'h4;
    localparam logic [3:0]  CMD_RECEIVE    = 4'h8;
    localparam logic [3:0]  CMD_TRANSCEIVE = 4'hc;
    // shortest frame kept when fragments are rejected
    localparam logic [7:0]  MIN_FRAG_BITS  = 8'h04;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_WAIT = 3'b010,
        RX_BUSY = 3'b100
    } rx_state_t;

    // seed lookup by two-bit code
    function automatic logic [15:0] seed_of(input logic [1:0] code);
        case (code)
            2'b00:   seed_of = SEED_0;
            2'b01:   seed_of = SEED_1;
            2'b10:   seed_of = SEED_2;
            default: seed_of = SEED_3;
        endcase
    endfunction : seed_of
endpackage : nfc_mode_pkg

// >>> src/nfc_tx_rx_mode_config.sv
// mode configuration for transmit and receive paths, wishbone slave
// assumes the framer/decoder report frame ends and bit counts
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
module nfc_tx_rx_mode_config
    import nfc_mode_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // transmit side
    input  wire logic        tx_busy_i,
    input  wire logic        mod_bit_i,
    input  wire logic        mod_valid_i,
    output logic             tx_bit_o,
    output logic             tx_valid_o,
    output logic             tx_crc_enable_o,
    output logic [2:0]       tx_bit_rate_o,
    output logic [1:0]       tx_frame_format_o,
    // receive side
    input  wire logic        rx_frame_end_i,
    input  wire logic [7:0]  rx_frame_bits_i,
    output logic             rx_crc_enable_o,
    output logic [2:0]       rx_bit_rate_o,
    output logic [1:0]       rx_frame_format_o,
    output logic             rx_enable_o,
    output logic             rx_frame_keep_o,
    output logic             rx_frame_drop_o,
    output logic             cmd_done_o,
    // crc coprocessor seed
    output logic [15:0]      crc_seed_o
);
    logic [7:0]  mode_r;
    logic [7:0]  tx_mode_r;
    logic [7:0]  rx_mode_r;
    logic [3:0]  command_r;
    logic [3:0]  command_nxt;
    rx_state_t   rx_state_r;
    rx_state_t   rx_state_nxt;
    logic [31:0] rdata_r;
    logic        ack_r;
    logic        err_r;
    logic        keep_r;
    logic        drop_r;
    logic        done_r;
    logic [15:0] seed_r;
    logic [7:0]  tx_cfg_r;
    logic [7:0]  rx_cfg_r;
    logic        rx_en_r;

    // bus decode
    wire logic       req;
    wire logic       wr;
    wire logic [7:0] idx;
    wire logic       hit_mode;
    wire logic       hit_tx;
    wire logic       hit_rx;
    wire logic       hit_cmd;
    wire logic       hit_st;
    wire logic       mapped;
    wire logic       wr_lane;
    assign req      = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
    assign wr       = req & wb_we_i & mapped & wr_lane;
    assign idx      = wb_adr_i[9:2];
    assign hit_mode = (idx == IDX_MODE);
    assign hit_tx   = (idx == IDX_TX_MODE);
    assign hit_rx   = (idx == IDX_RX_MODE);
    assign hit_cmd  = (idx == IDX_COMMAND);
    assign hit_st   = (idx == IDX_RX_STATUS);
    assign mapped   = hit_mode | hit_tx | hit_rx | hit_cmd | hit_st;
    assign wr_lane  = wb_sel_i[0];

    // per-register write strobes
    wire logic wr_mode;
    wire logic wr_tx;
    wire logic wr_rx;
    assign wr_mode = wr & hit_mode;
    assign wr_tx   = wr & hit_tx;
    assign wr_rx   = wr & hit_rx;

    // host write data for the writable registers
    wire logic [7:0] wd;
    wire logic       cmd_write;
    wire logic       multi_clear;
    assign wd          = wb_dat_i[7:0];
    assign cmd_write   = wr & hit_cmd;
    assign multi_clear = wr_rx & ~wd[MULTI_BIT];

    // receiver control fields
    wire logic multi;
    wire logic noerr;
    wire logic short_frag;
    wire logic rx_cmd;
    wire logic rf_active;
    assign multi      = rx_mode_r[MULTI_BIT];
    assign noerr      = rx_mode_r[NOERR_BIT];
    assign short_frag = noerr & (rx_frame_bits_i < MIN_FRAG_BITS);
    assign rx_cmd     = (command_r == CMD_RECEIVE)
                      | (command_r == CMD_TRANSCEIVE);
    assign rf_active  = tx_busy_i | (rx_state_r != RX_IDLE);

    // frame end seen while the receiver listens
    wire logic frame_in;
    wire logic frame_kept;
    wire logic frame_dropped;
    assign frame_in      = (rx_state_r != RX_IDLE) & rx_frame_end_i;
    assign frame_kept    = frame_in & ~short_frag;
    assign frame_dropped = frame_in & short_frag;

    // receive state and command next values
    always_comb begin
        rx_state_nxt = rx_state_r;
        command_nxt  = command_r;
        case (rx_state_r)
            RX_IDLE: begin
                if (rx_cmd) begin
                    rx_state_nxt = RX_WAIT;
                end
            end
            RX_WAIT, RX_BUSY: begin
                if (!rx_cmd) begin
                    rx_state_nxt = RX_IDLE;
                end else if (rx_frame_end_i && !short_frag) begin
                    if (multi) begin
                        rx_state_nxt = RX_BUSY;
                    end else begin
                        rx_state_nxt = RX_IDLE;
                        command_nxt  = CMD_IDLE;
                    end
                end
            end
            default: begin
                rx_state_nxt = RX_IDLE;
            end
        endcase
        // reception stops on any command write other than receive, or multi cleared in RX_BUSY
        if (cmd_write) begin
            command_nxt = wd[3:0];
            if (wd[3:0] != CMD_RECEIVE) begin
                rx_state_nxt = RX_IDLE;
            end
        end else if (multi_clear && rx_state_r == RX_BUSY) begin
            rx_state_nxt = RX_IDLE;
            command_nxt  = CMD_IDLE;
        end
    end

    // read mux
    wire logic [7:0] cmd_byte;
    wire logic [7:0] state_byte;
    wire logic [7:0] rd_byte;
    assign cmd_byte   = {4'h0, command_r};
    assign state_byte = {5'h00, rx_state_r};
    assign rd_byte = hit_mode ? mode_r
                   : hit_tx   ? tx_mode_r
                   : hit_rx   ? rx_mode_r
                   : hit_cmd  ? cmd_byte
                   : hit_st   ? state_byte
                   : 8'h00;

    // register fields feeding the seed and shaper
    wire logic [1:0] seed_code;
    wire logic [1:0] tx_framing;
    wire logic       invert;
    assign seed_code  = mode_r[1:0];
    assign tx_framing = tx_mode_r[FRAME_LSB +: 2];
    assign invert     = tx_mode_r[INV_BIT];

    // seed selection
    wire logic [15:0] seed_w;
    nfc_crc_seed u_seed (
        .crc_seed_select_i (seed_code),
        .rf_active_i       (rf_active),
        .tx_frame_format_i (tx_framing),
        .seed_o            (seed_w)
    );

    // transmit inversion
    nfc_tx_shaper u_shaper (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .mod_bit_i   (mod_bit_i),
        .mod_valid_i (mod_valid_i),
        .invert_i    (invert),
        .tx_bit_o    (tx_bit_o),
        .tx_valid_o  (tx_valid_o)
    );

    // configuration registers
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mode_r    <= MODE_RST;
            tx_mode_r <= TX_MODE_RST;
            rx_mode_r <= RX_MODE_RST;
        end else begin
            if (wr_mode) begin
                mode_r <= wd;
            end
            if (wr_tx) begin
                tx_mode_r <= wd & 8'hfb; // bit 2 reserved
            end
            if (wr_rx) begin
                rx_mode_r <= wd;
            end
        end
    end

    // command and receive state
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            command_r  <= COMMAND_RST;
            rx_state_r <= RX_IDLE;
        end else begin
            command_r  <= command_nxt;
            rx_state_r <= rx_state_nxt;
        end
    end

    // frame outcome pulses
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            keep_r <= 1'b0;
            drop_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            keep_r <= frame_kept;
            drop_r <= frame_dropped;
            done_r <= (rx_state_r != RX_IDLE) & (rx_state_nxt == RX_IDLE);
        end
    end

    // receiver enable level, registered for the output
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rx_en_r <= 1'b0;
        end else begin
            rx_en_r <= (rx_state_nxt != RX_IDLE);
        end
    end

    // crc seed towards the coprocessor
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            seed_r <= SEED_0;
        end else begin
            seed_r <= seed_w;
        end
    end

    // field copies towards the rf paths
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tx_cfg_r <= TX_MODE_RST;
            rx_cfg_r <= RX_MODE_RST;
        end else begin
            tx_cfg_r <= tx_mode_r;
            rx_cfg_r <= rx_mode_r;
        end
    end

    // read data for the answer, zero on writes
    wire logic [31:0] rdata_nxt;
    assign rdata_nxt = (req && !wb_we_i) ? {24'h00_0000, rd_byte}
                                         : 32'h0000_0000;

    // bus answer: one cycle after the request, error on unmapped
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ack_r   <= 1'b0;
            err_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r   <= req & mapped;
            err_r   <= req & ~mapped;
            rdata_r <= rdata_nxt;
        end
    end

    // bus and configuration outputs, all from flops
    assign wb_dat_o          = rdata_r;
    assign wb_ack_o          = ack_r;
    assign wb_err_o          = err_r;
    assign tx_crc_enable_o   = tx_cfg_r[CRC_EN_BIT];
    assign tx_bit_rate_o     = tx_cfg_r[RATE_LSB +: 3];
    assign tx_frame_format_o = tx_cfg_r[FRAME_LSB +: 2];
    assign rx_crc_enable_o   = rx_cfg_r[CRC_EN_BIT];
    assign rx_bit_rate_o     = rx_cfg_r[RATE_LSB +: 3];
    assign rx_frame_format_o = rx_cfg_r[FRAME_LSB +: 2];

    // receiver outcome and seed outputs
    assign rx_enable_o       = rx_en_r;
    assign rx_frame_keep_o   = keep_r;
    assign rx_frame_drop_o   = drop_r;
    assign cmd_done_o        = done_r;
    assign crc_seed_o        = seed_r;
endmodule : nfc_tx_rx_mode_config

// >>> src/nfc_tx_shaper.sv
// transmit bit shaping: optional output inversion
// assumes modulated data arrives one bit per clock with a valid
`timescale 1ns/1ps
module nfc_tx_shaper (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic mod_bit_i,
    input  wire logic mod_valid_i,
    input  wire logic invert_i,
    output logic      tx_bit_o,
    output logic      tx_valid_o
);
    logic tx_bit_r;
    logic tx_valid_r;
    // registered, optionally inverted stream
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tx_bit_r   <= 1'b0;
            tx_valid_r <= 1'b0;
        end else begin
            tx_bit_r   <= mod_valid_i & (mod_bit_i ^ invert_i);
            tx_valid_r <= mod_valid_i;
        end
    end
    assign tx_bit_o   = tx_bit_r;
    assign tx_valid_o = tx_valid_r;
endmodule : nfc_tx_shaper
